// ### cio_pkg.sv
package cio_pkg;

  localparam int NUM_PORTS = 3;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // Register indices; the byte address of each is four times its index.
  localparam logic [IDX_W-1:0] IDX_LATCH [NUM_PORTS] = '{10'h080, 10'h090, 10'h0A0};
  localparam logic [IDX_W-1:0] IDX_MODE_A [NUM_PORTS] = '{10'h084, 10'h091, 10'h0A4};
  localparam logic [IDX_W-1:0] IDX_MODE_B [NUM_PORTS] = '{10'h085, 10'h092, 10'h0A5};
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0C0;

  // Implemented bits of each mode register; all other bits read as zero.
  localparam logic [7:0] MODE_A_MASK [NUM_PORTS] = '{8'h78, 8'h83, 8'hF7};
  localparam logic [7:0] MODE_B_MASK [NUM_PORTS] = '{8'h78, 8'h83, 8'h03};
  // Bits of the mode registers that select a pin drive type.
  localparam logic [7:0] MODE_PIN_MASK [NUM_PORTS] = '{8'h78, 8'h83, 8'h03};
  localparam logic [7:0] MODE_RESET = 8'h00;

  // Spare-bit positions in the port 2 mode select A register.
  localparam int SCHMITT_BIT0 = 5;
  localparam int CLK_OUT_BIT = 4;
  localparam int T0_TOGGLE_BIT = 2;

  // Pins with fixed behaviour.
  localparam logic [7:0] P1_OPEN_DRAIN_MASK = 8'h0C;
  localparam logic [7:0] P1_RESET_PIN_MASK = 8'h20;
  localparam logic [7:0] P1_ALWAYS_SCHMITT = 8'h2C;
  localparam logic [7:0] P2_XTAL_MASK = 8'h03;

  // Strong pull-up assist length in CPU clocks.
  localparam int STRONG_PULSE_CYCLES = 2;
  localparam logic [1:0] STRONG_RELOAD = 2'(STRONG_PULSE_CYCLES - 1);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CIO_MODE_QUASI = 2'b00,
    CIO_MODE_PUSH = 2'b01,
    CIO_MODE_INPUT = 2'b10,
    CIO_MODE_OPEN = 2'b11
  } cio_mode_t;

  typedef struct packed {
    logic reset_level_high_select;
    logic crystal_osc;
    logic internal_reset;
  } cio_cfg_t;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pull_down;
    logic [7:0] strong_up;
    logic [7:0] weak_up;
    logic [7:0] very_weak_up;
    logic [7:0] input_en;
    logic [7:0] schmitt;
  } cio_drive_t;

endpackage

// ### cio_port_block.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module cio_port_block (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire cio_pkg::cio_cfg_t USER_CFG,
  input wire logic [7:0] PORT0_IN,
  input wire logic [7:0] PORT1_IN,
  input wire logic [7:0] PORT2_IN,
  output cio_pkg::cio_drive_t PORT0_DRV,
  output cio_pkg::cio_drive_t PORT1_DRV,
  output cio_pkg::cio_drive_t PORT2_DRV,
  output logic TIMER0_TOGGLE_OUT_EN,
  output logic CLOCK_OUT_EN,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  localparam int NP = cio_pkg::NUM_PORTS;

  logic init_q;
  cio_pkg::cio_cfg_t cfg_q;
  logic [7:0] latch_q [NP];
  logic [7:0] mode_a_q [NP];
  logic [7:0] mode_b_q [NP];
  logic [7:0] pin_in [NP];
  logic [7:0] sync1_q [NP];
  logic [7:0] sync2_q [NP];
  logic [7:0] pin_en [NP];
  wire cio_pkg::cio_drive_t drv_w [NP];

  logic aw_full_q;
  logic w_full_q;
  logic [9:0] aw_idx_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic t0_q;
  logic clk_out_q;

  logic do_write;
  logic wr_hit_c;
  logic [31:0] rd_data_c;
  logic rd_hit_c;
  logic [9:0] rd_idx;

  assign pin_in[0] = PORT0_IN;
  assign pin_in[1] = PORT1_IN;
  assign pin_in[2] = PORT2_IN;

  // One-cycle init phase after reset release catches the configuration straps.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      init_q <= 1'b1;
      cfg_q <= '0;
    end else if (init_q) begin
      init_q <= 1'b0;
      cfg_q <= USER_CFG;
    end
  end

  // Two-stage synchronisers on every pin input.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      for (int p = 0; p < NP; p++) begin
        sync1_q[p] <= 8'h00;
        sync2_q[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        sync1_q[p] <= pin_in[p];
        sync2_q[p] <= sync1_q[p];
      end
    end
  end

  // Pins that the oscillator and reset options take away from the port.
  always_comb begin
    pin_en[0] = 8'hFF;
    pin_en[1] = cfg_q.internal_reset ? 8'hFF : ~cio_pkg::P1_RESET_PIN_MASK;
    pin_en[2] = cfg_q.crystal_osc ? ~cio_pkg::P2_XTAL_MASK : 8'hFF;
  end

  assign do_write = aw_full_q && w_full_q && !bvalid_q;

  // Write address decode for the held address.
  always_comb begin
    wr_hit_c = (aw_idx_q == cio_pkg::IDX_STATUS);
    for (int p = 0; p < NP; p++) begin
      if (aw_idx_q == cio_pkg::IDX_LATCH[p] || aw_idx_q == cio_pkg::IDX_MODE_A[p] ||
          aw_idx_q == cio_pkg::IDX_MODE_B[p]) begin
        wr_hit_c = 1'b1;
      end
    end
  end

  // Port latches: constant under reset, loaded at the init edge, then written by software.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      for (int p = 0; p < NP; p++) begin
        latch_q[p] <= 8'h00;
      end
    end else if (init_q) begin
      for (int p = 0; p < NP; p++) begin
        latch_q[p] <= {8{USER_CFG.reset_level_high_select}};
      end
    end else if (do_write && wstrb0_q) begin
      for (int p = 0; p < NP; p++) begin
        if (aw_idx_q == cio_pkg::IDX_LATCH[p]) begin
          latch_q[p] <= wdata_q;
        end
      end
    end
  end

  // Mode registers clear to quasi drive; only implemented bits are stored.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      for (int p = 0; p < NP; p++) begin
        mode_a_q[p] <= cio_pkg::MODE_RESET;
        mode_b_q[p] <= cio_pkg::MODE_RESET;
      end
    end else if (do_write && wstrb0_q) begin
      for (int p = 0; p < NP; p++) begin
        if (aw_idx_q == cio_pkg::IDX_MODE_A[p]) begin
          mode_a_q[p] <= wdata_q & cio_pkg::MODE_A_MASK[p];
        end
        if (aw_idx_q == cio_pkg::IDX_MODE_B[p]) begin
          mode_b_q[p] <= wdata_q & cio_pkg::MODE_B_MASK[p];
        end
      end
    end
  end

  // Spare-bit enables; clock out is only honoured without a crystal.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      t0_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      t0_q <= mode_a_q[2][cio_pkg::T0_TOGGLE_BIT];
      clk_out_q <= mode_a_q[2][cio_pkg::CLK_OUT_BIT] && !cfg_q.crystal_osc;
    end
  end

  // Per-pin drive logic.
  for (genvar p = 0; p < NP; p++) begin : g_port
    for (genvar b = 0; b < 8; b++) begin : g_bit
      cio_pkg::cio_mode_t mode;
      logic configurable;
      logic latch;
      logic rise;
      logic schmitt_c;
      logic prev_q;
      logic [1:0] cnt_q;
      logic pd_q;
      logic su_q;
      logic wu_q;
      logic vw_q;
      logic ie_q;
      logic sch_q;

      assign configurable = cio_pkg::MODE_PIN_MASK[p][b];
      assign latch = latch_q[p][b];
      assign rise = latch && !prev_q;

      // Effective drive type after the fixed-pin overrides.
      always_comb begin
        if (p == 1 && cio_pkg::P1_OPEN_DRAIN_MASK[b]) begin
          mode = cio_pkg::CIO_MODE_OPEN;
        end else if (p == 1 && cio_pkg::P1_RESET_PIN_MASK[b]) begin
          mode = cio_pkg::CIO_MODE_INPUT;
        end else if (configurable) begin
          mode = cio_pkg::cio_mode_t'({mode_a_q[p][b], mode_b_q[p][b]});
        end else begin
          mode = cio_pkg::CIO_MODE_QUASI;
        end
      end

      // Threshold select is per port, with fixed Schmitt pins on port 1.
      assign schmitt_c = mode_a_q[2][cio_pkg::SCHMITT_BIT0 + p] ||
        (p == 1 && cio_pkg::P1_ALWAYS_SCHMITT[b]);

      // Strong pull-up assist timer; the init load is not a rising edge.
      always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
          prev_q <= 1'b0;
          cnt_q <= 2'h0;
        end else begin
          prev_q <= init_q ? USER_CFG.reset_level_high_select : latch;
          if (rise) begin
            cnt_q <= cio_pkg::STRONG_RELOAD;
          end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
      end

      // Registered driver controls, one edge after the latch or mode changes.
      always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
          pd_q <= 1'b0;
          su_q <= 1'b0;
          wu_q <= 1'b0;
          vw_q <= 1'b0;
          ie_q <= 1'b0;
          sch_q <= 1'b0;
        end else if (!pin_en[p][b] || init_q) begin
          pd_q <= 1'b0;
          su_q <= 1'b0;
          wu_q <= 1'b0;
          vw_q <= 1'b0;
          ie_q <= 1'b0;
          sch_q <= !init_q && p == 1 && cio_pkg::P1_ALWAYS_SCHMITT[b];
        end else begin
          ie_q <= 1'b1;
          sch_q <= schmitt_c;
          case (mode)
            cio_pkg::CIO_MODE_QUASI: begin
              pd_q <= !latch;
              vw_q <= latch;
              wu_q <= latch && sync2_q[p][b];
              su_q <= latch && (rise || cnt_q != 2'h0);
            end
            cio_pkg::CIO_MODE_PUSH: begin
              pd_q <= !latch;
              vw_q <= 1'b0;
              wu_q <= 1'b0;
              su_q <= latch;
            end
            cio_pkg::CIO_MODE_OPEN: begin
              pd_q <= !latch;
              vw_q <= 1'b0;
              wu_q <= 1'b0;
              su_q <= 1'b0;
            end
            cio_pkg::CIO_MODE_INPUT: begin
              pd_q <= 1'b0;
              vw_q <= 1'b0;
              wu_q <= 1'b0;
              su_q <= 1'b0;
            end
            default: begin
              pd_q <= 1'b0;
              vw_q <= 1'b0;
              wu_q <= 1'b0;
              su_q <= 1'b0;
            end
          endcase
        end
      end

      assign drv_w[p].pin_out[b] = su_q;
      assign drv_w[p].pin_oe[b] = su_q | pd_q;
      assign drv_w[p].pull_down[b] = pd_q;
      assign drv_w[p].strong_up[b] = su_q;
      assign drv_w[p].weak_up[b] = wu_q;
      assign drv_w[p].very_weak_up[b] = vw_q;
      assign drv_w[p].input_en[b] = ie_q;
      assign drv_w[p].schmitt[b] = sch_q;
    end
  end

  assign PORT0_DRV = drv_w[0];
  assign PORT1_DRV = drv_w[1];
  assign PORT2_DRV = drv_w[2];
  assign TIMER0_TOGGLE_OUT_EN = t0_q;
  assign CLOCK_OUT_EN = clk_out_q;

  // Write channel: address and data are held independently until the write is done.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_idx_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= cio_pkg::RESP_OKAY;
    end else if (init_q) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end else begin
      if (S_AXI_AWVALID && awready_q) begin
        aw_full_q <= 1'b1;
        aw_idx_q <= S_AXI_AWADDR[11:2];
        awready_q <= 1'b0;
      end
      if (S_AXI_WVALID && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q <= S_AXI_WDATA[7:0];
        wstrb0_q <= S_AXI_WSTRB[0];
        wready_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit_c ? cio_pkg::RESP_OKAY : cio_pkg::RESP_SLVERR;
      end
      if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // Read decode; port registers return the synchronised pin levels.
  assign rd_idx = S_AXI_ARADDR[11:2];
  always_comb begin
    rd_data_c = 32'h0000_0000;
    rd_hit_c = 1'b0;
    if (rd_idx == cio_pkg::IDX_STATUS) begin
      rd_hit_c = 1'b1;
      rd_data_c = {29'h0, cfg_q};
    end
    for (int p = 0; p < NP; p++) begin
      if (rd_idx == cio_pkg::IDX_LATCH[p]) begin
        rd_hit_c = 1'b1;
        rd_data_c = {24'h0, sync2_q[p] & pin_en[p]};
      end
      if (rd_idx == cio_pkg::IDX_MODE_A[p]) begin
        rd_hit_c = 1'b1;
        rd_data_c = {24'h0, mode_a_q[p]};
      end
      if (rd_idx == cio_pkg::IDX_MODE_B[p]) begin
        rd_hit_c = 1'b1;
        rd_data_c = {24'h0, mode_b_q[p]};
      end
    end
  end

  // Read channel: one read under way at a time.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= cio_pkg::RESP_OKAY;
    end else if (init_q) begin
      arready_q <= 1'b1;
    end else if (S_AXI_ARVALID && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_data_c;
      rresp_q <= rd_hit_c ? cio_pkg::RESP_OKAY : cio_pkg::RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

endmodule

// ### cio_port_block_asserts.sv
`timescale 1ns/1ps
module cio_port_block_asserts (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire cio_pkg::cio_cfg_t USER_CFG,
  input wire logic [7:0] PORT0_IN,
  input wire cio_pkg::cio_drive_t PORT0_DRV,
  input wire cio_pkg::cio_drive_t PORT1_DRV,
  input wire cio_pkg::cio_drive_t PORT2_DRV,
  input wire logic CLOCK_OUT_EN
);
  logic [1:0] up_q;
  logic live;

  // Counts the first edges after reset, before the drive outputs are valid.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  assign live = (up_q == 2'h3);

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  // Drive enables are checked against each other, the pin inputs and the USER_CFG strap inputs.
  chk_up_down_excl: assert property ((PORT0_DRV.strong_up & PORT0_DRV.pull_down) == 8'h00)
    else $error("strong pull-up and pull-down on together");
  chk_weak_latch: assert property ((PORT0_DRV.weak_up & ~PORT0_DRV.very_weak_up) == 8'h00)
    else $error("weak pull-up without very weak pull-up");
  chk_weak_pin: assert property (live |-> (PORT0_DRV.weak_up & ~$past(PORT0_IN, 3)) == 8'h00)
    else $error("weak pull-up on while pin was low");
  chk_strong_pulse: assert property ($rose(PORT0_DRV.strong_up[6]) && PORT0_DRV.very_weak_up[6]
    |=> PORT0_DRV.strong_up[6] ##1 !PORT0_DRV.strong_up[6])
    else $error("strong pull-up pulse not two clocks");
  chk_fixed_open: assert property (live |-> (PORT1_DRV.strong_up & 8'h0C) == 8'h00)
    else $error("fixed open-drain pin driven high");
  chk_schmitt_fixed: assert property (live |-> (PORT1_DRV.schmitt & 8'h2C) == 8'h2C)
    else $error("fixed Schmitt pins lost Schmitt input");
  chk_init_quiet: assert property (!live |->
    (PORT0_DRV.strong_up | PORT1_DRV.strong_up | PORT2_DRV.strong_up) == 8'h00)
    else $error("strong pull-up right after reset");
  chk_xtal_dead: assert property (live && USER_CFG.crystal_osc |->
    ((PORT2_DRV.pin_oe | PORT2_DRV.input_en) & 8'h03) == 8'h00)
    else $error("oscillator pins not disabled");
  chk_reset_pin: assert property (live && !USER_CFG.internal_reset |-> !PORT1_DRV.input_en[5])
    else $error("reset pin used as input");
  chk_clkout_xtal: assert property (live && USER_CFG.crystal_osc |-> !CLOCK_OUT_EN)
    else $error("clock out enabled with crystal");

  // Main scenarios reached.
  cover property ($rose(PORT0_DRV.strong_up[6]));
  cover property (PORT0_DRV.weak_up != 8'h00);
  cover property (live && USER_CFG.crystal_osc);
endmodule

// ### cio_pin_model.sv
`timescale 1ns/1ps
module cio_pin_model (
  input wire logic clk,
  input wire cio_pkg::cio_drive_t drv,
  input wire logic [7:0] ext_low,
  output logic [7:0] pin
);
  logic [7:0] float_q = 8'h55;

  // Undriven pins wander so that a floating input never reads steady.
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Pull-down and an external sink win over every pull-up.
  assign pin = ~drv.pull_down & ~ext_low
    & (drv.strong_up | drv.weak_up | drv.very_weak_up | float_q);
endmodule

// ### cio_port_block_tb.sv
`timescale 1ns/1ps
module cio_port_block_tb;
  localparam logic [11:0] MADDR [6] = '{12'h210, 12'h214, 12'h244, 12'h248, 12'h290, 12'h294};
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  cio_pkg::cio_cfg_t USER_CFG = 3'b000;
  logic [7:0] PORT0_IN, PORT1_IN, PORT2_IN;
  cio_pkg::cio_drive_t PORT0_DRV, PORT1_DRV, PORT2_DRV;
  logic TIMER0_TOGGLE_OUT_EN, CLOCK_OUT_EN;
  logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic [7:0] lo0 = 8'h00;
  logic [31:0] d;
  int err_count = 0;
  int checks_done = 0;
  int n;

  cio_port_block dut_u (
    .REF_CLK, .RESET, .USER_CFG, .PORT0_IN, .PORT1_IN, .PORT2_IN,
    .PORT0_DRV, .PORT1_DRV, .PORT2_DRV, .TIMER0_TOGGLE_OUT_EN, .CLOCK_OUT_EN,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY
  );
  cio_pin_model pm0_u (.clk(REF_CLK), .drv(PORT0_DRV), .ext_low(lo0), .pin(PORT0_IN));
  cio_pin_model pm1_u (.clk(REF_CLK), .drv(PORT1_DRV), .ext_low(8'h00), .pin(PORT1_IN));
  cio_pin_model pm2_u (.clk(REF_CLK), .drv(PORT2_DRV), .ext_low(8'h00), .pin(PORT2_IN));

  // The clock runs at 10 MHz.
  initial begin
    forever #50 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge REF_CLK);
    #1;
  endtask

  // Offers address and data together and drops each once it is taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, ok;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    #1;
    while (S_AXI_AWVALID || S_AXI_WVALID) begin
      ta = S_AXI_AWREADY;
      tw = S_AXI_WREADY;
      @(posedge REF_CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      #1;
    end
    ok = 1'b0;
    while (!ok) begin
      ok = S_AXI_BVALID;
      rs = S_AXI_BRESP;
      @(posedge REF_CLK);
      if (ok) begin
        S_AXI_BREADY <= 1'b0;
      end else begin
        #1;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ok;
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    #1;
    ok = 1'b0;
    while (!ok) begin
      ok = S_AXI_ARREADY;
      @(posedge REF_CLK);
      if (ok) begin
        S_AXI_ARVALID <= 1'b0;
      end else begin
        #1;
      end
    end
    #1;
    ok = 1'b0;
    while (!ok) begin
      ok = S_AXI_RVALID;
      v = S_AXI_RDATA;
      rs = S_AXI_RRESP;
      @(posedge REF_CLK);
      if (ok) begin
        S_AXI_RREADY <= 1'b0;
      end else begin
        #1;
      end
    end
  endtask

  task automatic do_reset();
    RESET <= 1'b1;
    repeat (16) @(posedge REF_CLK);
    RESET <= 1'b0;
    settle();
  endtask

  task automatic final_report();
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge REF_CLK);
    err_count++;
    final_report();
  end

  // Reset low with external reset pin, then reset high with crystal and internal reset.
  initial begin
    do_reset();
    foreach (MADDR[i]) begin
      rd(MADDR[i], d, r);
      chk(d, 32'h0);
    end
    rd(12'h300, d, r);
    chk(d, 32'h0);
    chk(PORT0_DRV.pull_down, 8'hFF);
    chk(PORT0_DRV.very_weak_up, 8'h00);
    wr(12'h200, 32'hFF, r);
    n = 0;
    repeat (6) begin
      #1;
      n += PORT0_DRV.strong_up[6];
      @(posedge REF_CLK);
    end
    chk(n, 2);
    chk(PORT0_DRV.very_weak_up, 8'hFF);
    chk(PORT0_DRV.pull_down, 8'h00);
    settle();
    chk(PORT0_DRV.weak_up, 8'hFF);
    lo0 <= 8'h08;
    settle();
    chk(PORT0_DRV.weak_up, 8'hF7);
    rd(12'h200, d, r);
    chk(d, 32'hF7);
    lo0 <= 8'h00;
    // Bit 3 push-pull, bit 4 input only, bit 5 open drain, bit 6 quasi.
    wr(12'h210, 32'h30, r);
    wr(12'h214, 32'h28, r);
    settle();
    chk(PORT0_DRV.strong_up, 8'h08);
    chk(PORT0_DRV.pin_out, 8'h08);
    chk(PORT0_DRV.very_weak_up, 8'hC7);
    chk(PORT0_DRV.pin_oe, 8'h08);
    rd(12'h210, d, r);
    chk(d, 32'h30);
    wr(12'h200, 32'h00, r);
    #1;
    chk(PORT0_DRV.pull_down, 8'hEF);
    settle();
    chk(PORT0_DRV.pull_down, 8'hEF);
    chk(PORT0_DRV.strong_up, 8'h00);
    wr(12'h240, 32'hFF, r);
    #1;
    chk(PORT1_DRV.strong_up, 8'hD3);
    chk(PORT1_DRV.input_en[5], 1'b0);
    chk(PORT1_DRV.schmitt, 8'h2C);
    wr(12'h290, 32'h94, r);
    settle();
    chk({TIMER0_TOGGLE_OUT_EN, CLOCK_OUT_EN}, 2'h3);
    chk(PORT2_DRV.schmitt, 8'hFF);
    chk(PORT0_DRV.schmitt, 8'h00);
    rd(12'h290, d, r);
    chk(d, 32'h94);
    rd(12'h3FC, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, 32'h0000_0002);
    wr(12'h204, 32'h0, r);
    chk(r, 2'h2);
    USER_CFG <= 3'b111;
    do_reset();
    rd(12'h300, d, r);
    chk(d, 32'h7);
    chk(PORT0_DRV.very_weak_up, 8'hFF);
    chk(PORT0_DRV.pull_down, 8'h00);
    chk(PORT2_DRV.input_en & 8'h03, 8'h00);
    chk(PORT1_DRV.input_en[5], 1'b1);
    wr(12'h290, 32'h10, r);
    settle();
    chk(CLOCK_OUT_EN, 1'b0);
    final_report();
  end
endmodule

bind cio_port_block cio_port_block_asserts chk_u (
  .REF_CLK, .RESET, .USER_CFG, .PORT0_IN, .PORT0_DRV, .PORT1_DRV, .PORT2_DRV, .CLOCK_OUT_EN
);
